// ===== include/sarp_pkg.sv
/*
 * Shared constants and types of the converter result readout port.
 * Assumes a 250 MHz system clock and a host-driven shift clock.
 */
package sarp_pkg;

    // ****************************************************************
    // Bus modes and word selects
    // ****************************************************************
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_WORD16 = 2'h1;
    localparam logic [1:0] MODE_BYTE8 = 2'h2;
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam logic [1:0] SEL_HIGH = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_LOW = 2'h2;
    localparam int RESULT_W = 18;
    localparam int BUS_W = 18;
    localparam int SERIAL_PIN = 12;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ACQ_TIME_PS = 77000;
    localparam int ACQ_CYCLES = (ACQ_TIME_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int CONV_TIME_PS = 310000;
    localparam int CONV_CYCLES = CONV_TIME_PS / CLK_PERIOD_PS;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [1:0] bus_mode;
        logic format_a;
        logic format_b;
        logic low_layout;
    } sarp_cfg_t;

    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic [BUS_W-1:0] data_oe_n;
    } sarp_bus_t;

    typedef enum logic [1:0] {
        ST_ACQ = 2'b00,
        ST_READY = 2'b01,
        ST_CONV = 2'b11
    } sarp_state_t;

endpackage

// ===== rtl/sarp_shift_link.sv
/*
 * Serial shift-out link of the result readout port.
 * Runs wholly on the host shift clock; result and load request arrive
 * from the system domain, the request as a toggle.
 * The system reset clears the link asynchronously; the host must keep
 * the shift clock idle while that reset is released.
 */
`timescale 1ns/1ps
module sarp_shift_link (
    // Link clock and reset
    input wire logic shift_clk,
    input wire logic link_rst,
    // From system domain
    input wire logic [sarp_pkg::RESULT_W-1:0] result,
    input wire logic load_toggle,
    // Chain input and serial output
    input wire logic serial_chain_in,
    output logic serial_out
);
    import sarp_pkg::*;

    logic [RESULT_W-1:0] shreg;
    logic [RESULT_W-1:0] next_shreg;
    logic sync1;
    logic sync2;
    logic seen;
    logic next_seen;
    logic chain_bit;
    logic fell;
    logic next_fell;
    logic out_q;
    logic next_out_q;

    // A fresh result is noticed a couple of shift edges after it is
    // made; the host waits for busy low, so edges are plentiful.
    // Both sides start at the idle toggle level; otherwise the first
    // load after reset could never be told apart from the old state.
    always_ff @(posedge shift_clk or posedge link_rst) begin
        if (link_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= load_toggle;
            sync2 <= sync1;
        end
    end

    // Chain input sampled on falling edges.
    always_ff @(negedge shift_clk) begin
        chain_bit <= serial_chain_in;
    end

    always_comb begin
        next_seen = sync2;
        next_shreg = shreg;
        next_fell = fell;
        next_out_q = out_q;
        if (sync2 != seen) begin
            next_shreg = result;
            next_fell = 1'b0;
            next_out_q = result[RESULT_W-1];
        end else begin
            next_fell = 1'b1;
            // The first rising edge after load only arms the shift so
            // that the top bit stays until a falling edge has passed.
            if (fell) begin
                // Shift MSB first, chain bit fills behind.
                next_shreg = {shreg[RESULT_W-2:0], chain_bit};
                next_out_q = shreg[RESULT_W-2];
            end
        end
    end

    // Output changes only after rising edges.
    always_ff @(posedge shift_clk or posedge link_rst) begin
        if (link_rst) begin
            seen <= 1'b0;
            shreg <= '0;
            fell <= 1'b0;
            out_q <= 1'b0;
        end else begin
            seen <= next_seen;
            shreg <= next_shreg;
            fell <= next_fell;
            out_q <= next_out_q;
        end
    end

    assign serial_out = out_q;
endmodule

// ===== rtl/sarp_readout.sv
/*
 * Result readout, format and reset logic of an 18-bit sampling
 * converter. Holds the conversion sequencer, parallel bus drive and
 * the serial link instance.
 * Assumes pins from outside are asynchronous; the serial link is
 * clocked by the host shift clock.
 */
//
// Contract
// - Mode 01 gives two 16-bit words on top pins.
// - Low two pins select word in 16-bit mode.
// - Mode 10 gives three bytes on top pins.
// - Word select picks byte in 8-bit mode.
// - Two layouts for lowest two result bits.
// - Chip select gates narrow bus drivers.
// - Mode 11 shifts result out serially.
// - Serial output changes after rising shift edges.
// - Top bit holds past first falling edge.
// - Chain input follows result after 18 cycles.
// - Chain input sampled on falling edges.
// - Format pins set coding in all modes.
// - Reset high tri-states data bus.
// - Reset aborts conversion at once.
// - Starts ignored while reset is high.
// - After reset, start only after acquisition.
// - Mode 00 gives full 18-bit word.
// - Chip select high tri-states, low drives.
// - Start falling edge converts, busy high meanwhile.
`timescale 1ns/1ps
module sarp_readout (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic shift_clk,
    // Converter pins
    input wire logic reset_pin,
    input wire logic conversion_start_n,
    input wire logic chip_select_n,
    input wire logic [1:0] bus_mode,
    input wire logic format_select_a,
    input wire logic format_select_b,
    input wire logic low_layout,
    input wire logic word_select_bit0_pin,
    input wire logic word_select_bit1_pin,
    input wire logic serial_chain_in,
    // Raw sample from the analog core
    input wire logic [sarp_pkg::RESULT_W-1:0] raw_sample,
    // Outputs
    output sarp_pkg::sarp_bus_t data_bus,
    output logic busy
);
    import sarp_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] next_s1;
    sarp_cfg_t cfg;
    logic rst_pin_s;
    logic start_n_s;
    logic cs_n_s;
    logic [1:0] wsel;

    always_comb begin
        next_s1 = {low_layout, reset_pin, conversion_start_n, chip_select_n,
                   bus_mode, format_select_a, format_select_b,
                   word_select_bit1_pin, word_select_bit0_pin};
    end

    always_ff @(posedge clk) begin
        s1 <= next_s1;
        s2 <= s1;
    end

    assign rst_pin_s = s2[8];
    assign start_n_s = s2[7];
    assign cs_n_s = s2[6];
    assign cfg.bus_mode = s2[5:4];
    assign cfg.format_a = s2[3];
    assign cfg.format_b = s2[2];
    assign cfg.low_layout = s2[9];
    assign wsel = s2[1:0];

    // ****************************************************************
    // Output coding
    // ****************************************************************
    // Table contents are not known; straight binary or top bit inverted
    // for offset coding, and format_a shifts right by one, repeating the top bit.
    function automatic logic [RESULT_W-1:0] code_of(
        input logic [RESULT_W-1:0] raw, input logic fa, input logic fb);
        logic [RESULT_W-1:0] c;
        c = raw;
        if (fb) begin
            c[RESULT_W-1] = ~raw[RESULT_W-1];
        end
        if (fa) begin
            c = {c[RESULT_W-1], c[RESULT_W-1:1]};
        end
        return c;
    endfunction

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    sarp_state_t state;
    sarp_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic start_prev;
    logic next_start_prev;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] next_result;
    logic load_toggle;
    logic next_load_toggle;
    logic next_busy;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_result = result;
        next_load_toggle = load_toggle;
        next_busy = busy;
        next_start_prev = start_n_s;
        if (rst_pin_s) begin
            // Abort and hold off starts while reset is high.
            next_state = ST_ACQ;
            next_cnt = 8'(ACQ_CYCLES);
            next_busy = 1'b0;
        end else begin
            case (state)
                ST_ACQ: begin
                    // Acquisition must elapse before a start counts.
                    if (cnt == CNT_ZERO) begin
                        next_state = ST_READY;
                    end else begin
                        next_cnt = cnt - 8'h01;
                    end
                end
                ST_READY: begin
                    if (start_prev && !start_n_s) begin
                        next_state = ST_CONV;
                        next_cnt = 8'(CONV_CYCLES);
                        next_busy = 1'b1;
                    end
                end
                ST_CONV: begin
                    if (cnt == CNT_ZERO) begin
                        next_result = code_of(raw_sample, cfg.format_a,
                                              cfg.format_b);
                        next_load_toggle = ~load_toggle;
                        next_busy = 1'b0;
                        next_state = ST_ACQ;
                        next_cnt = 8'(ACQ_CYCLES);
                    end else begin
                        next_cnt = cnt - 8'h01;
                    end
                end
                default: begin
                    next_state = ST_ACQ;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_ACQ;
            cnt <= 8'(ACQ_CYCLES);
            start_prev <= 1'b1;
            result <= '0;
            load_toggle <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            start_prev <= next_start_prev;
            result <= next_result;
            load_toggle <= next_load_toggle;
            busy <= next_busy;
        end
    end

    // ****************************************************************
    // Serial link
    // ****************************************************************
    logic serial_bit;
    logic ser_s1;
    logic ser_s2;

    sarp_shift_link u_link (
        .shift_clk(shift_clk),
        .link_rst(sys_rst),
        .result(result),
        .load_toggle(load_toggle),
        .serial_chain_in(serial_chain_in),
        .serial_out(serial_bit)
    );

    // The serial pin is re-timed into the system clock here; a host
    // that needs exact edge timing should tap the link output itself.
    always_ff @(posedge clk) begin
        ser_s1 <= serial_bit;
        ser_s2 <= ser_s1;
    end

    // ****************************************************************
    // Parallel bus drive
    // ****************************************************************
    sarp_bus_t next_bus;
    logic [1:0] low2;

    always_comb begin
        next_bus.data = '0;
        next_bus.data_oe_n = '1;
        // Two layouts of the lowest bits: top-aligned or right-aligned.
        low2 = result[1:0];
        case (cfg.bus_mode)
            MODE_FULL: begin
                next_bus.data = result;
                next_bus.data_oe_n = '0;
            end
            MODE_WORD16: begin
                next_bus.data_oe_n = {{16{1'b0}}, 2'h3};
                if (wsel == SEL_HIGH) begin
                    next_bus.data[17:2] = result[17:2];
                end else if (cfg.low_layout) begin
                    next_bus.data[3:2] = low2;
                end else begin
                    next_bus.data[17:16] = low2;
                end
            end
            MODE_BYTE8: begin
                next_bus.data_oe_n = {{8{1'b0}}, 10'h3ff};
                if (wsel == SEL_HIGH) begin
                    next_bus.data[17:10] = result[17:10];
                end else if (wsel == SEL_MID) begin
                    next_bus.data[17:10] = result[9:2];
                end else if (cfg.low_layout) begin
                    next_bus.data[11:10] = low2;
                end else begin
                    next_bus.data[17:16] = low2;
                end
            end
            default: begin
                // Serial: only the shared data pin drives.
                next_bus.data[SERIAL_PIN] = ser_s2;
                next_bus.data_oe_n[SERIAL_PIN] = 1'b0;
            end
        endcase
        // Deselect or reset lets the pins float.
        if (cs_n_s || rst_pin_s) begin
            next_bus.data_oe_n = '1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_bus.data <= '0;
            data_bus.data_oe_n <= '1;
        end else begin
            data_bus <= next_bus;
        end
    end
endmodule

// ===== testbench/sarp_readout_checker.sv
/* Pin-level assertions for the result readout port.
   Assumes binding to sarp_readout and sight of its ports only. */
`timescale 1ns/1ps
module sarp_readout_checker (
    // Clocks and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic shift_clk,
    input wire logic reset_pin,
    // Control pins
    input wire logic conversion_start_n,
    input wire logic chip_select_n,
    input wire logic [1:0] bus_mode,
    input wire logic format_select_a,
    input wire logic format_select_b,
    input wire logic low_layout,
    input wire logic word_select_bit0_pin,
    input wire logic word_select_bit1_pin,
    input wire logic serial_chain_in,
    input wire logic [sarp_pkg::RESULT_W-1:0] raw_sample,
    // Outputs
    input wire sarp_pkg::sarp_bus_t data_bus,
    input wire logic busy
);
    import sarp_pkg::*;
    // ****************************************************************
    // Busy counters
    // ****************************************************************
    // The low count restarts on the raw reset pin, two cycles ahead of
    // the design's synchroniser, so it can only overstate the gap.
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    logic [7:0] next_hi_cnt;
    logic [7:0] next_lo_cnt;
    logic lane_on;
    always_comb begin
        next_hi_cnt = busy ? hi_cnt + 8'h01 : CNT_ZERO;
        next_lo_cnt = lo_cnt + {7'h00, lo_cnt != 8'hff};
        if (busy || reset_pin) begin
            next_lo_cnt = CNT_ZERO;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_cnt <= CNT_ZERO;
            lo_cnt <= CNT_ZERO;
        end else begin
            hi_cnt <= next_hi_cnt;
            lo_cnt <= next_lo_cnt;
        end
    end
    assign lane_on = !chip_select_n && !reset_pin;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_reset_float: assert property (reset_pin [*5] |->
        &data_bus.data_oe_n) else $error("bus driven in reset");
    chk_reset_abort: assert property (reset_pin [*5] |-> !busy)
        else $error("conversion kept in reset");
    chk_reset_nostart: assert property (reset_pin [*5]
        ##0 $fell(conversion_start_n) |=> !busy [*4])
        else $error("start taken in reset");
    chk_acq_gap: assert property ($rose(busy) |->
        lo_cnt >= ACQ_CYCLES) else $error("start inside acquisition");
    chk_busy_len: assert property ($fell(busy) && !reset_pin &&
        !$past(reset_pin) && !$past(reset_pin, 2) && !$past(reset_pin, 3)
        |-> hi_cnt == CONV_CYCLES + 1) else $error("busy length wrong");
    chk_cs_float: assert property (chip_select_n [*5] |->
        &data_bus.data_oe_n) else $error("bus driven while deselected");
    chk_full_drive: assert property ((lane_on &&
        bus_mode == MODE_FULL) [*5] |-> data_bus.data_oe_n == 18'h00000)
        else $error("full bus not driven");
    chk_word_drive: assert property ((lane_on &&
        bus_mode == MODE_WORD16) [*5] |-> data_bus.data_oe_n == 18'h00003)
        else $error("word lane drive wrong");
    chk_byte_drive: assert property ((lane_on &&
        bus_mode == MODE_BYTE8) [*5] |-> data_bus.data_oe_n[17:10] ==
        8'h00 && data_bus.data_oe_n[1:0] == 2'h3)
        else $error("byte lane drive wrong");
    chk_serial_pin: assert property ((lane_on &&
        bus_mode == MODE_SERIAL) [*5] |-> !data_bus.data_oe_n[SERIAL_PIN])
        else $error("serial pin not driven");
endmodule
bind sarp_readout sarp_readout_checker i_sarp_readout_checker (.*);

// ===== testbench/sarp_host_model.sv
/* Host side of the serial link: makes whole frames of shift clock.
   Assumes the serial pin is fed back as the chain input. */
`timescale 1ns/1ps
module sarp_host_model (
    // Frame request and device serial pin
    input wire logic go,
    input wire logic serial_in,
    // Link clock and chain line
    output logic shift_clk,
    output logic chain_out,
    // Captured bits
    output logic [63:0] stream,
    output logic done
);
    initial begin
        shift_clk = 1'b0;
        chain_out = 1'b0;
        stream = 64'h0;
        done = 1'b0;
    end
    // The clock stands still outside frames and runs only after busy
    // has fallen; a frame is never cut short.
    always @(posedge go) begin
        done = 1'b0;
        #13;
        repeat (42) begin
            shift_clk = 1'b1;
            #28;
            chain_out = serial_in;
            stream = {stream[62:0], serial_in};
            #4;
            shift_clk = 1'b0;
            #32;
        end
        chain_out = ~chain_out;
        done = 1'b1;
    end
endmodule

// ===== testbench/sarp_readout_test.sv
/* Self-checking bench of the readout port.
   Assumes the checker is bound and the host model drives the link. */
`timescale 1ns/1ps
module sarp_readout_test;
    import sarp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_pin = 1'b0;
    logic conversion_start_n = 1'b1;
    logic chip_select_n = 1'b0;
    logic [1:0] bus_mode = MODE_FULL;
    logic format_select_a = 1'b0;
    logic format_select_b = 1'b0;
    logic low_layout = 1'b0;
    logic [1:0] wsel = SEL_HIGH;
    logic [RESULT_W-1:0] raw_sample = 18'h00000;
    logic go = 1'b0;
    logic shift_clk, serial_chain_in, done, busy;
    logic [63:0] stream;
    sarp_bus_t data_bus;
    // A released pin has no pull, so the host sees it flip, not hold.
    logic [17:0] pins;
    assign pins = data_bus.data ^ data_bus.data_oe_n;
    int err_count = 0;
    int samples_checked = 0;
    logic [17:0] exp_q[$];
    logic [17:0] mask_q[$];
    logic [17:0] ser_q[$];
    event note_ev;
    sarp_readout i_sarp_readout (
        .clk(clk), .sys_rst(sys_rst), .shift_clk(shift_clk),
        .reset_pin(reset_pin), .conversion_start_n(conversion_start_n),
        .chip_select_n(chip_select_n), .bus_mode(bus_mode),
        .format_select_a(format_select_a),
        .format_select_b(format_select_b),
        .low_layout(low_layout), .word_select_bit0_pin(wsel[0]),
        .word_select_bit1_pin(wsel[1]), .serial_chain_in(serial_chain_in),
        .raw_sample(raw_sample), .data_bus(data_bus), .busy(busy)
    );
    sarp_host_model i_sarp_host_model (
        .go(go), .serial_in(pins[SERIAL_PIN]),
        .shift_clk(shift_clk), .chain_out(serial_chain_in),
        .stream(stream), .done(done)
    );
    always #2 clk = ~clk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("Checks: %0d, mismatches: %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic convert(input logic [17:0] v);
        int n;
        raw_sample = v;
        conversion_start_n = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (busy !== 1'b1) begin
            err_count++;
            end_sim();
        end
        conversion_start_n = 1'b1;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        if (busy !== 1'b0) begin
            err_count++;
            end_sim();
        end
        tick(24);
    endtask
    // Only the pins that carry the chosen word are compared.
    task automatic read_word(input logic [1:0] sel, input logic [17:0] v);
        logic [17:0] want;
        logic [17:0] mask;
        logic b8;
        b8 = bus_mode == MODE_BYTE8;
        wsel = sel;
        tick(5);
        if (bus_mode == MODE_FULL) begin
            want = v;
            mask = 18'h3ffff;
        end else if (sel == SEL_HIGH) begin
            want = b8 ? {v[17:10], 10'h000} : {v[17:2], 2'h0};
            mask = b8 ? 18'h3fc00 : 18'h3fffc;
        end else if (sel == SEL_MID && b8) begin
            want = {v[9:2], 10'h000};
            mask = 18'h3fc00;
        end else if (!low_layout) begin
            want = {v[1:0], 16'h0000};
            mask = 18'h30000;
        end else begin
            want = b8 ? {6'h00, v[1:0], 10'h000} : {14'h0000, v[1:0], 2'h0};
            mask = b8 ? 18'h00c00 : 18'h0000c;
        end
        exp_q.push_back(want);
        mask_q.push_back(mask);
        ->note_ev;
    endtask
    // ****************************************************************
    // Monitors and watchdog
    // ****************************************************************
    always @(note_ev) begin
        check(pins & mask_q.pop_front(), exp_q.pop_front());
    end
    always @(posedge done) begin
        logic [17:0] w;
        logic hit;
        w = ser_q.pop_front();
        hit = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (stream[i +: 36] === {w, w}) hit = 1'b1;
        end
        check({17'h00000, hit}, 18'h00001);
    end
    initial begin
        #100000;
        err_count++;
        end_sim();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [17:0] v;
        int n;
        void'($urandom(90));
        tick(6);
        sys_rst = 1'b0;
        tick(30);
        for (int m = 0; m < 3; m++) begin
            for (int lay = 0; lay < 2; lay++) begin
                bus_mode = m[1:0];
                low_layout = lay[0];
                format_select_b = m == 0 && lay == 1;
                format_select_a = m == 1 && lay == 1;
                v = 18'($urandom);
                convert(v);
                v = v ^ {format_select_b, 17'h00000};
                if (format_select_a) begin
                    v = {v[17], v[17:1]};
                end
                for (int s = 0; s < 4; s++) begin
                    read_word(s[1:0], v);
                end
            end
        end
        chip_select_n = 1'b1;
        tick(8);
        chip_select_n = 1'b0;
        read_word(SEL_HIGH, v);
        raw_sample = 18'h2aaaa;
        conversion_start_n = 1'b0;
        tick(10);
        conversion_start_n = 1'b1;
        tick(20);
        reset_pin = 1'b1;
        tick(8);
        conversion_start_n = 1'b0;
        tick(3);
        conversion_start_n = 1'b1;
        tick(8);
        reset_pin = 1'b0;
        conversion_start_n = 1'b0;
        tick(3);
        conversion_start_n = 1'b1;
        tick(40);
        convert(18'h15555);
        read_word(SEL_HIGH, 18'h15555);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(30);
        bus_mode = MODE_SERIAL;
        format_select_b = 1'b1;
        v = 18'($urandom);
        convert(v);
        ser_q.push_back(v ^ 18'h20000);
        go = 1'b1;
        tick(1);
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        if (done !== 1'b1) begin
            err_count++;
            end_sim();
        end
        go = 1'b0;
        tick(2);
        end_sim();
    end
endmodule
